// file: rtl/ifp_defs.svh
// Constants for the instruction fetch pipeline and program counter
`ifndef IFP_DEFS_SVH
`define IFP_DEFS_SVH
`define IFP_PHASES 4
`define IFP_PC_RESET 11'h000
`define IFP_REG_PCL 4'h0
`define IFP_REG_PCH 4'h1
`define IFP_REG_STATUS 4'h2
`define IFP_REG_CTRL 4'h3
`define IFP_CTRL_RUN 0
`define IFP_CTRL_RESET 8'h01
`define IFP_ST_IDLE 0
`define IFP_ST_BRANCH 1
`define IFP_PAGE_BITS 8
`endif

// file: rtl/ifp_fetch_seq.sv
// Instruction fetch sequencer with program counter
// What this block does
// - four non-overlapping phases from system clock
// - PC advances and fetch starts at T1
// - phases two to four decode and execute
// - four phases make one instruction cycle
// - fetch overlaps execute, one per cycle
// - non-sequential transfers take two cycles
// - first cycle target, second cycle transfer
// - otherwise PC increments by one
// - PC 10 or 11 bits, low byte visible
// - jump, call, interrupt, reset load PC
// - taken skip discards prefetch, idle cycle
// - low byte write branches in page, idle
// - reset sets PC to zero
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "ifp_defs.svh"
module ifp_fetch_seq #(
   parameter int PC_WIDTH = 11,
   parameter int WORD_WIDTH = 15
)
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [3:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [7:0] REG_RDATA_OUT,
   input wire logic [WORD_WIDTH-1:0] MEM_DATA_IN,
   output logic [PC_WIDTH-1:0] MEM_ADDR_OUT,
   output logic MEM_RD_OUT,
   input wire ifp_pkg::ifp_op_t EXEC_OP_IN,
   input wire logic [PC_WIDTH-1:0] EXEC_TARGET_IN,
   input wire logic IRQ_ACK_IN,
   input wire logic [PC_WIDTH-1:0] IRQ_VECTOR_IN,
   output logic [WORD_WIDTH-1:0] INSTR_OUT,
   output logic INSTR_VALID_OUT,
   output logic [3:0] PHASE_OUT,
   output logic EXEC_STROBE_OUT,
   output logic IDLE_CYCLE_OUT
);
   import ifp_pkg::*;

   ////////////////////////////////////////////////////////////
   // Phase generation
   logic run_r;
   ifp_phase_if ph ();
   ifp_phase_gen u_phase
   (
      .clk_in(SYS_CLK_IN),
      .rst_n_in(RST_N_IN),
      .run_in(run_r),
      .ph(ph.gen)
   );

   ////////////////////////////////////////////////////////////
   // Register decode
   function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
      reg_hit = (a == off);
   endfunction

   logic pcl_wr;
   logic ctrl_wr;
   assign pcl_wr = REG_WR_IN && reg_hit(REG_ADDR_IN, `IFP_REG_PCL);
   assign ctrl_wr = REG_WR_IN && reg_hit(REG_ADDR_IN, `IFP_REG_CTRL);

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         run_r <= 1'b1;
      else if (ctrl_wr)
         run_r <= REG_WDATA_IN[`IFP_CTRL_RUN];
   end

   ////////////////////////////////////////////////////////////
   // Pending low-byte write, taken at the next fetch phase so the PC changes only at T1
   logic pcl_pend_r;
   logic [7:0] pcl_val_r;
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         pcl_pend_r <= 1'b0;
         pcl_val_r <= 8'h00;
      end
      else if (pcl_wr)
      begin
         pcl_pend_r <= 1'b1;
         pcl_val_r <= REG_WDATA_IN;
      end
      else if (ph.fetch_phase)
         pcl_pend_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // Program counter and pipeline
   logic [PC_WIDTH-1:0] pc_r;
   logic [PC_WIDTH-1:0] pc_nxt;
   logic flush_r;
   logic flush_nxt;
   logic exec_t4;
   logic [PC_WIDTH-1:0] pending_target_r;
   logic pending_load_r;
   logic pending_skip_r;

   assign exec_t4 = run_r && (ph.phase == IFP_T4) && INSTR_VALID_OUT;

   // Latch the transfer decided during execute; acted on at the following T1
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         pending_load_r <= 1'b0;
         pending_skip_r <= 1'b0;
         pending_target_r <= '0;
      end
      else if (IRQ_ACK_IN)
      begin
         pending_load_r <= 1'b1;
         pending_skip_r <= 1'b0;
         pending_target_r <= IRQ_VECTOR_IN;
      end
      else if (exec_t4 && !pending_load_r)
      begin
         // target obtained first cycle; a pending interrupt load keeps priority
         pending_load_r <= (EXEC_OP_IN == IFP_OP_BRANCH);
         pending_skip_r <= (EXEC_OP_IN == IFP_OP_SKIP);
         pending_target_r <= EXEC_TARGET_IN;
      end
      else if (ph.fetch_phase)
      begin
         pending_load_r <= 1'b0;
         pending_skip_r <= 1'b0;
      end
   end

   always_comb
   begin
      pc_nxt = pc_r;
      flush_nxt = flush_r;
      if (ph.fetch_phase)
      begin
         flush_nxt = 1'b0;
         if (pending_load_r)
         begin
            pc_nxt = pending_target_r;
            flush_nxt = 1'b1;
         end
         else if (pcl_pend_r)
         begin
            pc_nxt = {pc_r[PC_WIDTH-1:`IFP_PAGE_BITS], pcl_val_r};
            flush_nxt = 1'b1;
         end
         else
         begin
            pc_nxt = pc_r + {{(PC_WIDTH-1){1'b0}}, 1'b1};
            flush_nxt = pending_skip_r;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         pc_r <= PC_WIDTH'(`IFP_PC_RESET);
         flush_r <= 1'b1;
      end
      else
      begin
         pc_r <= pc_nxt;
         flush_r <= flush_nxt;
      end
   end

   ////////////////////////////////////////////////////////////
   // Fetch: address presented in T1, word captured at end of T1
   // advance and fetch
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         // Read stands through the first T1 so the word at address zero is taken
         MEM_ADDR_OUT <= '0;
         MEM_RD_OUT <= 1'b1;
      end
      else
      begin
         MEM_ADDR_OUT <= pc_nxt;
         MEM_RD_OUT <= run_r && (ph.phase == IFP_T4);
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         INSTR_OUT <= '0;
         INSTR_VALID_OUT <= 1'b0;
         IDLE_CYCLE_OUT <= 1'b0;
      end
      else if (ph.fetch_phase)
      begin
         INSTR_OUT <= MEM_DATA_IN;
         INSTR_VALID_OUT <= !flush_nxt;
         IDLE_CYCLE_OUT <= flush_nxt;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         PHASE_OUT <= 4'h0;
         EXEC_STROBE_OUT <= 1'b0;
      end
      else
      begin
         PHASE_OUT <= run_r ? ph.phase : 4'h0;
         EXEC_STROBE_OUT <= run_r && (ph.phase == IFP_T3) && INSTR_VALID_OUT;
      end
   end

   ////////////////////////////////////////////////////////////
   // Read port; upper PC bits are not readable, the status view holds only flush and valid
   // low byte visible
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         REG_RDATA_OUT <= 8'h00;
      else if (REG_RD_IN)
      begin
         case (REG_ADDR_IN)
            `IFP_REG_PCL: REG_RDATA_OUT <= pc_r[7:0];
            `IFP_REG_STATUS: REG_RDATA_OUT <= {6'h00, flush_r, INSTR_VALID_OUT};
            `IFP_REG_CTRL: REG_RDATA_OUT <= {7'h00, run_r};
            default: REG_RDATA_OUT <= 8'h00;
         endcase
      end
      else
         REG_RDATA_OUT <= 8'h00;
   end

   ////////////////////////////////////////////////////////////
   // Checks
   sequence s_branch_exec;
      exec_t4 && EXEC_OP_IN == IFP_OP_BRANCH && !IRQ_ACK_IN && !pending_load_r;
   endsequence
   chk_pc_t1_only: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !ph.fetch_phase |=> $stable(pc_r))
      else $error("PC changed outside T1");
   chk_pc_incr: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      ph.fetch_phase && !pending_load_r && !pcl_pend_r |=> pc_r == $past(pc_r) + 1'b1)
      else $error("PC not incremented");
   chk_branch_load: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      s_branch_exec ##1 (!IRQ_ACK_IN && !pcl_wr) |=> pc_r == $past(EXEC_TARGET_IN, 2))
      else $error("branch target not loaded");
   chk_branch_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      s_branch_exec |=> ##1 IDLE_CYCLE_OUT && !INSTR_VALID_OUT)
      else $error("branch missing idle cycle");
   chk_skip_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      exec_t4 && EXEC_OP_IN == IFP_OP_SKIP && !IRQ_ACK_IN && !pending_load_r |=> ##1 IDLE_CYCLE_OUT)
      else $error("skip did not discard");
   chk_pcl_page: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      ph.fetch_phase && pcl_pend_r && !pending_load_r |=> pc_r[PC_WIDTH-1:8] == $past(pc_r[PC_WIDTH-1:8]))
      else $error("low byte write left page");
   chk_exec_phase: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      EXEC_STROBE_OUT |-> PHASE_OUT == IFP_T3)
      else $error("execute strobe outside execute phases");
   chk_cycle_len: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      ph.fetch_phase && run_r ##1 run_r[*3] |=> ph.fetch_phase)
      else $error("instruction cycle not four phases");
endmodule

// file: rtl/ifp_phase_gen.sv
// Four non-overlapping phase generator
`timescale 1ns/1ns
module ifp_phase_gen
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   ifp_phase_if.gen ph
);
   import ifp_pkg::*;
   ifp_phase_t phase_r;
   ////////////////////////////////////////////////////////////
   // one-hot rotation
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         phase_r <= IFP_T1;
      else if (run_in)
      begin
         case (phase_r)
            IFP_T1: phase_r <= IFP_T2;
            IFP_T2: phase_r <= IFP_T3;
            IFP_T3: phase_r <= IFP_T4;
            IFP_T4: phase_r <= IFP_T1;
            default: phase_r <= IFP_T1;
         endcase
      end
   end
   assign ph.phase = phase_r;
   assign ph.fetch_phase = run_in && (phase_r == IFP_T1);
   chk_phase_onehot: assert property (@(posedge clk_in) disable iff (!rst_n_in) $onehot(phase_r))
      else $error("phase not one-hot");
endmodule

// file: rtl/ifp_phase_if.sv
// Phase strobes shared between the phase generator and the sequencer
`timescale 1ns/1ns
interface ifp_phase_if;
   import ifp_pkg::*;
   ifp_phase_t phase;
   logic fetch_phase;
   modport gen (output phase, output fetch_phase);
   modport use_side (input phase, input fetch_phase);
endinterface

// file: rtl/ifp_pkg.sv
// Types for the instruction fetch pipeline
package ifp_pkg;
   typedef enum logic [3:0]
   {
      IFP_T1 = 4'h1,
      IFP_T2 = 4'h2,
      IFP_T3 = 4'h4,
      IFP_T4 = 4'h8
   } ifp_phase_t;
   typedef enum logic [1:0]
   {
      IFP_OP_NEXT = 2'h0,
      IFP_OP_BRANCH = 2'h1,
      IFP_OP_SKIP = 2'h2
   } ifp_op_t;
endpackage

// file: test/ifp_prog_mem.sv
// Program memory model that answers the fetch address
`timescale 1ns/1ns
module ifp_prog_mem #(
   parameter int AW = 11,
   parameter logic [3:0] TAG = 4'h5
)
(
   input wire logic [AW-1:0] addr_in,
   input wire logic rd_in,
   output logic [AW+3:0] data_out
);
   // Outside a fetch the bus shows the inverse, so a stale word never passes
   assign data_out = rd_in ? {TAG, addr_in} : ~{TAG, addr_in};
endmodule

// file: test/instruction_fetch_pipeline_pc_tb_top.sv
// Self-checking bench for the fetch sequencer and program counter
`timescale 1ns/1ns
`include "ifp_defs.svh"
module instruction_fetch_pipeline_pc_tb_top;
   import ifp_pkg::*;
   logic clk, rst_n, reg_wr, reg_rd, irq_ack, mem_rd, instr_valid, exec_strobe, idle_cycle, cur_i;
   logic [3:0] reg_addr, phase;
   logic [7:0] reg_wdata, reg_rdata;
   logic [10:0] mem_addr, exec_target, irq_vector;
   logic [14:0] mem_data, instr, cur_w;
   ifp_op_t exec_op;
   int miscompares, checks_done, s, r;
   ////////////////////////////////////////////////////////////////
   ifp_fetch_seq dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
      .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata), .MEM_DATA_IN(mem_data),
      .MEM_ADDR_OUT(mem_addr), .MEM_RD_OUT(mem_rd), .EXEC_OP_IN(exec_op), .EXEC_TARGET_IN(exec_target),
      .IRQ_ACK_IN(irq_ack), .IRQ_VECTOR_IN(irq_vector), .INSTR_OUT(instr), .INSTR_VALID_OUT(instr_valid),
      .PHASE_OUT(phase), .EXEC_STROBE_OUT(exec_strobe), .IDLE_CYCLE_OUT(idle_cycle));
   ifp_prog_mem mem (.addr_in(mem_addr), .rd_in(mem_rd), .data_out(mem_data));
   ////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Sample the word once it settled, then present the op for it
   task get(input ifp_op_t op, input logic [10:0] tgt);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (phase !== 4'h2 && n < 10);
      cur_w = instr;
      cur_i = idle_cycle;
      exec_op <= op;
      exec_target <= tgt;
   endtask
   task step(input ifp_op_t op, input logic [10:0] tgt, input logic [10:0] ea, input logic ei);
      get(op, tgt);
      chk({15'h0, cur_i}, {15'h0, ei}, "idle flag");
      if (!ei)
         chk({1'b0, cur_w}, {5'h05, ea}, "fetched word");
   endtask
   // The instruction already under way may still run before the dummy
   task expect_jump(input logic [10:0] ea);
      get(IFP_OP_NEXT, 11'h000);
      if (cur_i !== 1'b1)
         get(IFP_OP_NEXT, 11'h000);
      chk({15'h0, cur_i}, 16'h0001, "dummy cycle");
      step(IFP_OP_NEXT, 11'h000, ea, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      #(50 * 4000);
      miscompares++;
      final_report;
   end
   initial
   begin
      rst_n = 1'b0;
      {reg_wr, reg_rd, irq_ack, reg_addr, reg_wdata, exec_target, irq_vector} = '0;
      exec_op = IFP_OP_NEXT;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      get(IFP_OP_NEXT, 11'h000);
      if (cur_i === 1'b1)
         get(IFP_OP_NEXT, 11'h000);
      chk({1'b0, cur_w}, 16'h2800, "first word");
      step(IFP_OP_NEXT, 11'h000, 11'h001, 1'b0);
      step(IFP_OP_BRANCH, 11'h2A5, 11'h002, 1'b0);
      step(IFP_OP_NEXT, 11'h000, 11'h000, 1'b1);
      step(IFP_OP_NEXT, 11'h000, 11'h2A5, 1'b0);
      step(IFP_OP_SKIP, 11'h000, 11'h2A6, 1'b0);
      step(IFP_OP_NEXT, 11'h000, 11'h000, 1'b1);
      step(IFP_OP_NEXT, 11'h000, 11'h2A8, 1'b0);
      $display("test sequence, branch and skip done");
      reg_write(`IFP_REG_PCL, 8'h40);
      expect_jump(11'h240);
      irq_vector <= 11'h004;
      irq_ack <= 1'b1;
      @(posedge clk);
      irq_ack <= 1'b0;
      expect_jump(11'h004);
      reg_write(`IFP_REG_PCL, 8'hFF);
      expect_jump(11'h0FF);
      step(IFP_OP_NEXT, 11'h000, 11'h100, 1'b0);
      $display("test page write and interrupt done");
      reg_read(`IFP_REG_PCL, reg_wdata);
      chk({8'h0, reg_wdata}, 16'h0001, "low byte read");
      reg_read(`IFP_REG_PCH, reg_wdata);
      chk({8'h0, reg_wdata}, 16'h0000, "high bits read");
      reg_read(4'hF, reg_wdata);
      chk({8'h0, reg_wdata}, 16'h0000, "unmapped read");
      $display("test registers done");
      do
      begin
         @(posedge clk);
         #1;
      end
      while (phase !== 4'h1);
      s = 0;
      r = 0;
      for (int i = 0; i < 4; i++)
      begin
         chk({12'h0, phase}, 16'h0001 << i, "phase order");
         s += int'(exec_strobe);
         r += int'(mem_rd);
         @(posedge clk);
         #1;
      end
      chk(16'(s), 16'h0001, "exec strobes per cycle");
      chk(16'(r), 16'h0001, "fetch phases per cycle");
      $display("test phases done");
      final_report;
   end
endmodule
